// ---- rtl/uil_pkg.sv ----
// Constants, types and helpers of the serial port interrupt logic.
// Assumes a 32-bit classic Wishbone register bus and byte addressing.
//
// Summary of operation
// - Level interrupt only on crossing trigger point
// - Three-bit receive trigger field, five codes used
// - Three-bit transmit trigger field in low bits
// - Trigger levels reset to half full
// - Level select steers receive and transmit interrupts
// - Unsupported fields do nothing, read zero
// - Mask write sets or clears, read returns
// - Mask sources sit at fixed bits
// - Raw status shows unmasked source state
// - Raw status is read only
// - Status registers clear on reset
// - Masked status shows source after mask
// - Clear register one clears raw interrupt
package uil_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UIL_OFS_TRIG    = 8'h00;
    localparam logic [7:0] UIL_OFS_MASK    = 8'h04;
    localparam logic [7:0] UIL_OFS_RAW     = 8'h08;
    localparam logic [7:0] UIL_OFS_MASKED  = 8'h0c;
    localparam logic [7:0] UIL_OFS_CLEAR   = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         UIL_TX_TRIG_LSB = 0;
    localparam int         UIL_RX_TRIG_LSB = 3;
    localparam logic [2:0] UIL_TRIG_RST    = 3'h2;
    localparam logic [2:0] UIL_TRIG_MAX    = 3'h4;
    localparam int         UIL_SRC_HI_LSB  = 4;
    localparam int         UIL_CTS_BIT     = 1;
    localparam logic [7:0] UIL_MASK_RST    = 8'h00;
    localparam logic [7:0] UIL_STAT_RST    = 8'h00;

    // Interrupt sources, most significant first
    typedef struct packed {
        logic overrun;
        logic brk;
        logic parity;
        logic framing;
        logic rx_timeout;
        logic tx_level;
        logic rx_level;
        logic cts_change;
    } uil_src_type;

    // Source vector to register word
    function automatic logic [31:0] uil_to_word(input uil_src_type v);
        logic [7:0] b;
        b = v;
        uil_to_word = {21'h0, b[7:1], 2'h0, b[0], 1'h0};
    endfunction : uil_to_word

    // Register word to source vector
    function automatic uil_src_type uil_from_word(input logic [31:0] w);
        uil_from_word = {w[10:4], w[UIL_CTS_BIT]};
    endfunction : uil_from_word

endpackage : uil_pkg

// ---- rtl/uil_interrupt_logic.sv ----
// Interrupt trigger, mask and status logic of a serial port.
// Assumes FIFO fill counts and error pulses from logic on the same
// clock; the clear-to-send pin is asynchronous.
`timescale 1ns/100ps

module uil_interrupt_logic
    import uil_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W      = 5
) (
    // Clock and reset
    input  wire logic             SYS_CLK_IN,
    input  wire logic             ARST_N_IN,
    // Wishbone slave
    input  wire logic             WB_CYC_IN,
    input  wire logic             WB_STB_IN,
    input  wire logic             WB_WE_IN,
    input  wire logic [7:0]       WB_ADR_IN,
    input  wire logic [3:0]       WB_SEL_IN,
    input  wire logic [31:0]      WB_DAT_IN,
    output logic      [31:0]      WB_DAT_OUT,
    output logic                  WB_ACK_OUT,
    // FIFO fill levels
    input  wire logic [CNT_W-1:0] RX_FILL_IN,
    input  wire logic [CNT_W-1:0] TX_FILL_IN,
    // Error and timeout event pulses
    input  wire logic             OVERRUN_EVT_IN,
    input  wire logic             BREAK_EVT_IN,
    input  wire logic             PARITY_EVT_IN,
    input  wire logic             FRAMING_EVT_IN,
    input  wire logic             RX_TIMEOUT_EVT_IN,
    // Modem pin
    input  wire logic             CLEAR_TO_SEND_N_IN,
    // Interrupt outputs
    output uil_src_type           IRQ_VEC_OUT,
    output logic                  IRQ_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0]       rx_trig_q, tx_trig_q;
    uil_src_type      mask_q, raw_q;
    logic [CNT_W-1:0] rx_prev_q, tx_prev_q;
    logic [1:0]       cts_sync_q;
    logic             cts_last_q;
    logic             ack_q;
    logic [31:0]      rdata_q;

    // Trigger threshold in entries for a level code
    function automatic logic [CNT_W:0] trig_count(input logic [2:0] c);
        int n;
        unique case (c)
            3'h0:    n = FIFO_DEPTH / 8;
            3'h1:    n = FIFO_DEPTH / 4;
            3'h2:    n = FIFO_DEPTH / 2;
            3'h3:    n = (FIFO_DEPTH * 3) / 4;
            3'h4:    n = (FIFO_DEPTH * 7) / 8;
            default: n = FIFO_DEPTH / 2;
        endcase
        trig_count = n[CNT_W:0];
    endfunction : trig_count

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        bus_req   = WB_CYC_IN & WB_STB_IN;
    wire        wr_fire   = bus_req & WB_WE_IN & ack_q;
    wire [31:0] lane_mask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
                             {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    wire [31:0] wr_bits   = WB_DAT_IN & lane_mask;
    wire        hit_trig  = wr_fire & (WB_ADR_IN == UIL_OFS_TRIG)
                            & WB_SEL_IN[0];
    wire        hit_mask  = wr_fire & (WB_ADR_IN == UIL_OFS_MASK);
    wire        hit_clear = wr_fire & (WB_ADR_IN == UIL_OFS_CLEAR);

    // Mask merge by byte lane; bits 3, 2 and 0 are dropped
    wire [31:0]       mask_word = uil_to_word(mask_q);
    wire uil_src_type mask_new  = uil_from_word(
                            (mask_word & ~lane_mask) | wr_bits);
    wire uil_src_type clr_vec   = hit_clear ? uil_from_word(wr_bits)
                                            : UIL_STAT_RST;

    // ------------------------------------------------------------
    // Level crossing detection
    // ------------------------------------------------------------
    wire [CNT_W:0] rx_th  = trig_count(rx_trig_q);
    wire [CNT_W:0] tx_th  = trig_count(tx_trig_q);
    wire [CNT_W:0] rx_now = {1'b0, RX_FILL_IN};
    wire [CNT_W:0] rx_old = {1'b0, rx_prev_q};
    wire [CNT_W:0] tx_now = {1'b0, TX_FILL_IN};
    wire [CNT_W:0] tx_old = {1'b0, tx_prev_q};
    // Receive fires on rising through, transmit on draining through
    wire rx_cross = (rx_old < rx_th) & (rx_now >= rx_th);
    wire tx_cross = (tx_old > tx_th) & (tx_now <= tx_th);
    wire cts_edge = cts_sync_q[1] ^ cts_last_q;

    // Events of this cycle
    wire uil_src_type evt_vec = {OVERRUN_EVT_IN, BREAK_EVT_IN,
                                 PARITY_EVT_IN, FRAMING_EVT_IN,
                                 RX_TIMEOUT_EVT_IN, tx_cross,
                                 rx_cross, cts_edge};
    // Set wins over a clear in the same cycle
    wire uil_src_type raw_d   = evt_vec | (raw_q & ~clr_vec);
    wire uil_src_type masked  = raw_q & mask_q;

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [31:0] trig_word = {26'h0, rx_trig_q, tx_trig_q};
    wire [31:0] rd_mux =
        (WB_ADR_IN == UIL_OFS_TRIG)   ? trig_word :
        (WB_ADR_IN == UIL_OFS_MASK)   ? mask_word :
        (WB_ADR_IN == UIL_OFS_RAW)    ? uil_to_word(raw_q) :
        (WB_ADR_IN == UIL_OFS_MASKED) ? uil_to_word(masked) :
                                        32'h0;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Ack one cycle after the request, read data captured alongside
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= bus_req & ~ack_q;
            rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Trigger levels; reserved codes written are kept but act as half
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rx_trig_q <= UIL_TRIG_RST;
            tx_trig_q <= UIL_TRIG_RST;
        end else if (hit_trig) begin
            rx_trig_q <= WB_DAT_IN[UIL_RX_TRIG_LSB +: 3];
            tx_trig_q <= WB_DAT_IN[UIL_TX_TRIG_LSB +: 3];
        end
    end

    // Interrupt mask
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            mask_q <= UIL_MASK_RST;
        end else if (hit_mask) begin
            mask_q <= mask_new;
        end
    end

    // ------------------------------------------------------------
    // Status and history
    // ------------------------------------------------------------
    // Raw status changes only by events and the clear register
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            raw_q <= UIL_STAT_RST;
        end else begin
            raw_q <= raw_d;
        end
    end

    // Previous fill counts for crossing detection
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rx_prev_q <= '0;
            tx_prev_q <= '0;
        end else begin
            rx_prev_q <= RX_FILL_IN;
            tx_prev_q <= TX_FILL_IN;
        end
    end

    // Clear-to-send synchroniser and change history
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cts_sync_q <= 2'h3;
            cts_last_q <= 1'b1;
        end else begin
            cts_sync_q <= {cts_sync_q[0], CLEAR_TO_SEND_N_IN};
            cts_last_q <= cts_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign WB_ACK_OUT  = ack_q;
    assign WB_DAT_OUT  = rdata_q;
    assign IRQ_VEC_OUT = masked;
    assign IRQ_OUT     = |masked;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    sequence s_req_start;
        bus_req && !ack_q;
    endsequence

    sequence s_ack_pulse;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence

    a_ack_after_req: assert property (
        s_req_start |=> s_ack_pulse)
        else $error("ack did not follow request for one cycle");

    a_mask_write_lands: assert property (
        hit_mask && WB_SEL_IN == 4'hf
        |=> mask_q == $past(uil_from_word(WB_DAT_IN)))
        else $error("mask write not stored");

    a_mask_read_back: assert property (
        s_req_start and (!WB_WE_IN && WB_ADR_IN == UIL_OFS_MASK)
        |=> WB_DAT_OUT == uil_to_word(mask_q))
        else $error("mask read value wrong");

    a_raw_set_wins: assert property (
        OVERRUN_EVT_IN |=> raw_q.overrun)
        else $error("overrun event lost");

    a_raw_clear: assert property (
        hit_clear && WB_SEL_IN[1] && WB_DAT_IN[10] && !OVERRUN_EVT_IN
        |=> !raw_q.overrun)
        else $error("clear did not drop overrun");

    a_raw_read_only: assert property (
        hit_mask || hit_trig || (wr_fire && WB_ADR_IN == UIL_OFS_RAW)
        |-> raw_d == (evt_vec | raw_q))
        else $error("write altered raw status");

    a_masked_and: assert property (
        IRQ_VEC_OUT == (raw_q & mask_q))
        else $error("masked status not raw and mask");

    a_irq_or_all: assert property (
        IRQ_OUT == ((uil_to_word(raw_q) & mask_word) != 32'h0))
        else $error("combined interrupt wrong");

    a_rx_once_cross: assert property (
        $past(ARST_N_IN) && $past(RX_FILL_IN) >= rx_th[CNT_W-1:0]
        && !rx_th[CNT_W] && $stable(rx_trig_q) |-> !rx_cross)
        else $error("receive level fired without crossing");

    a_rx_cross_sets: assert property (
        rx_cross |=> raw_q.rx_level)
        else $error("receive crossing not recorded");

endmodule : uil_interrupt_logic

// ---- verif/test_uil_interrupt_logic.sv ----
// Self-checking bench of the serial port interrupt logic.
// Assumes the register map of uil_pkg and a one-cycle Wishbone answer.
`timescale 1ns/100ps

module test_uil_interrupt_logic
    import uil_pkg::*;
;
    logic        clk         = 1'b0;
    logic        arst_n      = 1'b0;
    logic        cyc         = 1'b0;
    logic        stb         = 1'b0;
    logic        we          = 1'b0;
    logic        cts_n       = 1'b1;
    logic [7:0]  adr         = 8'h00;
    logic [3:0]  sel         = 4'h0;
    logic [31:0] wdat        = 32'h0;
    logic [4:0]  rx_fill     = 5'h00;
    logic [4:0]  tx_fill     = 5'h00;
    logic [4:0]  evt         = 5'h00;
    logic [31:0] rdat;
    logic        ack;
    uil_src_type irq_vec;
    logic        irq;
    logic [31:0] q;
    int          num_errors  = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          th[5]       = '{2, 4, 8, 12, 14};

    // Clock, 20 ns period
    always #10 clk = ~clk;

    uil_interrupt_logic dut (
        .SYS_CLK_IN         (clk),
        .ARST_N_IN          (arst_n),
        .WB_CYC_IN          (cyc),
        .WB_STB_IN          (stb),
        .WB_WE_IN           (we),
        .WB_ADR_IN          (adr),
        .WB_SEL_IN          (sel),
        .WB_DAT_IN          (wdat),
        .WB_DAT_OUT         (rdat),
        .WB_ACK_OUT         (ack),
        .RX_FILL_IN         (rx_fill),
        .TX_FILL_IN         (tx_fill),
        .OVERRUN_EVT_IN     (evt[4]),
        .BREAK_EVT_IN       (evt[3]),
        .PARITY_EVT_IN      (evt[2]),
        .FRAMING_EVT_IN     (evt[1]),
        .RX_TIMEOUT_EVT_IN  (evt[0]),
        .CLEAR_TO_SEND_N_IN (cts_n),
        .IRQ_VEC_OUT        (irq_vec),
        .IRQ_OUT            (irq)
    );

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; waits for ack, hang guard ends a lost answer
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        chk(32'(n), 32'h2);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic pulse(input logic [4:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 5'h00;
    endtask : pulse

    task automatic fill(input int r, input int t);
        @(posedge clk);
        rx_fill <= 5'(r);
        tx_fill <= 5'(t);
    endtask : fill

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(UIL_OFS_TRIG, 32'h12);
        rd(UIL_OFS_MASK, 32'h0);
        rd(UIL_OFS_RAW, 32'h0);
        rd(UIL_OFS_MASKED, 32'h0);
        wb(1'b1, UIL_OFS_TRIG, 32'h0000_0019);
        rd(UIL_OFS_TRIG, 32'h19);
        wb(1'b1, UIL_OFS_MASK, 32'h0000_07f2);
        rd(UIL_OFS_MASK, 32'h7f2);
        wb(1'b1, UIL_OFS_MASK, 32'h0);
        rd(UIL_OFS_MASK, 32'h0);
        // Every level code: approach, cross, then hold at the level
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, UIL_OFS_TRIG, 32'(c * 9));
            fill(th[c] - 1, th[c] + 1);
            rd(UIL_OFS_RAW, 32'h0);
            fill(th[c], th[c]);
            rd(UIL_OFS_RAW, 32'h30);
            wb(1'b1, UIL_OFS_CLEAR, 32'h30);
            rd(UIL_OFS_RAW, 32'h0);
            fill(0, 0);
        end
        rd(UIL_OFS_RAW, 32'h0);
        // Each error source, enabled
        wb(1'b1, UIL_OFS_MASK, 32'h7f2);
        for (int i = 0; i < 5; i++) begin
            pulse(5'(1 << i));
            rd(UIL_OFS_RAW, 32'(1 << (6 + i)));
            rd(UIL_OFS_MASKED, 32'(1 << (6 + i)));
            chk({24'h0, irq_vec}, 32'(8 << i));
            chk({31'h0, irq}, 32'h1);
            wb(1'b1, UIL_OFS_RAW, 32'h0);
            rd(UIL_OFS_RAW, 32'(1 << (6 + i)));
            wb(1'b1, UIL_OFS_CLEAR, 32'(1 << (6 + i)));
            rd(UIL_OFS_RAW, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Masked source is held raw but not reported
        wb(1'b1, UIL_OFS_MASK, 32'h0);
        pulse(5'h10);
        rd(UIL_OFS_RAW, 32'h400);
        rd(UIL_OFS_MASKED, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, UIL_OFS_MASK, 32'h400);
        rd(UIL_OFS_MASKED, 32'h400);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, UIL_OFS_CLEAR, 32'h400);
        // Clear-to-send change
        wb(1'b1, UIL_OFS_MASK, 32'h2);
        @(posedge clk);
        cts_n <= 1'b0;
        repeat (5) @(posedge clk);
        rd(UIL_OFS_MASKED, 32'h2);
        chk({24'h0, irq_vec}, 32'h1);
        wb(1'b1, UIL_OFS_CLEAR, 32'h2);
        rd(UIL_OFS_RAW, 32'h0);
        // Second reset in mid-run with pending sources
        @(posedge clk);
        cts_n <= 1'b1;
        repeat (5) @(posedge clk);
        pulse(5'h1f);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rd(UIL_OFS_RAW, 32'h0);
        rd(UIL_OFS_MASK, 32'h0);
        rd(UIL_OFS_TRIG, 32'h12);
        tally_and_finish();
    end
endmodule : test_uil_interrupt_logic
